// ### include/bbme_pkg.sv
// Constants and types for the branch, bit and move execution block.
// Notes on behaviour
// (RULE1) Branch on negative flag set or clear
// (RULE2) Signed branches test negative xor overflow
// (RULE3) Branch on half-carry set or clear
// (RULE4) Branch on transfer flag set or clear
// (RULE5) Branch on overflow flag set or clear
// (RULE6) Branch on interrupt enable on or off
// (RULE7) I/O bit set or clear, two cycles
// (RULE8) Logical left shift, flags updated
// (RULE9) Logical right shift, flags updated
// (RULE10) Rotate left through carry, flags updated
// (RULE11) Rotate right through carry, flags updated
// (RULE12) Arithmetic right shift keeps bit seven
// (RULE13) Register bit to and from transfer flag
// (RULE14) Set or clear any single status flag
// (RULE15) Copy register or register pair, no flags
// (RULE16) Branch: one cycle skipped, two taken
package bbme_pkg;

  localparam int PC_W = 10;
  localparam int OFFSET_W = 7;
  localparam int BYTE_W = 8;
  localparam int GPR_N = 32;
  localparam int IO_N = 64;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IO_BASE = 8'h20;
  localparam logic [7:0] ADDR_IO_END = 8'h60;
  localparam logic [7:0] ADDR_FLAGS = 8'h60;
  localparam logic [7:0] ADDR_PC_LO = 8'h61;
  localparam logic [7:0] ADDR_PC_HI = 8'h62;

  // ----------------------------------------------------------------
  // Status flag positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_branch_if_negative = 5'h00,
    op_branch_if_positive = 5'h01,
    op_branch_signed_not_less = 5'h02,
    op_branch_signed_less = 5'h03,
    op_branch_half_carry_set = 5'h04,
    op_branch_half_carry_clear = 5'h05,
    op_branch_transfer_flag_set = 5'h06,
    op_branch_transfer_flag_clear = 5'h07,
    op_branch_overflow_set = 5'h08,
    op_branch_overflow_clear = 5'h09,
    op_branch_interrupts_on = 5'h0a,
    op_branch_interrupts_off = 5'h0b,
    op_io_bit_set = 5'h0c,
    op_io_bit_clear = 5'h0d,
    op_shift_left_logical = 5'h0e,
    op_shift_right_logical = 5'h0f,
    op_rotate_left_carry = 5'h10,
    op_rotate_right_carry = 5'h11,
    op_shift_right_arithmetic = 5'h12,
    op_store_bit_to_transfer_flag = 5'h13,
    op_load_bit_from_transfer_flag = 5'h14,
    op_flag_set = 5'h15,
    op_flag_clear = 5'h16,
    op_copy_register = 5'h17,
    op_copy_register_pair = 5'h18,
    op_none = 5'h1f
  } bbme_op_e;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_io_write = 2'b01,
    st_branch = 2'b10
  } bbme_state_e;

endpackage

// ### verilog/bbme_core.sv
// Execution core for branches, bit operations, shifts and moves.
`timescale 1ns/10ps
module bbme_core (
  input wire logic clock,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire bbme_pkg::bbme_op_e instr_op,
  input wire logic [4:0] instr_dst,
  input wire logic [4:0] instr_src,
  input wire logic [2:0] instr_bit,
  input wire logic [5:0] instr_io,
  input wire logic [6:0] instr_offset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic busy,
  output logic done,
  output logic [9:0] pc,
  output logic [7:0] flags
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [bbme_pkg::GPR_N-1:0][7:0] gpr;
    logic [bbme_pkg::IO_N-1:0][7:0] io;
    logic [7:0] flags;
    logic [bbme_pkg::PC_W-1:0] pc;
    bbme_pkg::bbme_state_e state;
    logic [bbme_pkg::PC_W-1:0] pend_pc;
    logic [5:0] pend_addr;
    logic [2:0] pend_bit;
    logic pend_val;
    logic busy;
    logic done;
    logic [7:0] rdata;
  } bbme_regs_s;

  bbme_regs_s s;
  bbme_regs_s next_s;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic bbme_is_branch(input bbme_pkg::bbme_op_e op);
    bbme_is_branch = (op <= bbme_pkg::op_branch_interrupts_off);
  endfunction

  function automatic logic bbme_cond(input bbme_pkg::bbme_op_e op, input logic [7:0] f);
    case (op)
      bbme_pkg::op_branch_if_negative: bbme_cond = f[bbme_pkg::FLAG_N]; // [RULE1]
      bbme_pkg::op_branch_if_positive: bbme_cond = !f[bbme_pkg::FLAG_N]; // [RULE1]
      bbme_pkg::op_branch_signed_not_less:
        bbme_cond = !(f[bbme_pkg::FLAG_N] ^ f[bbme_pkg::FLAG_V]); // [RULE2]
      bbme_pkg::op_branch_signed_less:
        bbme_cond = f[bbme_pkg::FLAG_N] ^ f[bbme_pkg::FLAG_V]; // [RULE2]
      bbme_pkg::op_branch_half_carry_set: bbme_cond = f[bbme_pkg::FLAG_H]; // [RULE3]
      bbme_pkg::op_branch_half_carry_clear: bbme_cond = !f[bbme_pkg::FLAG_H]; // [RULE3]
      bbme_pkg::op_branch_transfer_flag_set: bbme_cond = f[bbme_pkg::FLAG_T]; // [RULE4]
      bbme_pkg::op_branch_transfer_flag_clear: bbme_cond = !f[bbme_pkg::FLAG_T]; // [RULE4]
      bbme_pkg::op_branch_overflow_set: bbme_cond = f[bbme_pkg::FLAG_V]; // [RULE5]
      bbme_pkg::op_branch_overflow_clear: bbme_cond = !f[bbme_pkg::FLAG_V]; // [RULE5]
      bbme_pkg::op_branch_interrupts_on: bbme_cond = f[bbme_pkg::FLAG_I]; // [RULE6]
      bbme_pkg::op_branch_interrupts_off: bbme_cond = !f[bbme_pkg::FLAG_I]; // [RULE6]
      default: bbme_cond = 1'b0;
    endcase
  endfunction

  // Zero, carry, negative and overflow after a shift or rotate
  function automatic logic [7:0] bbme_shift_flags(input logic [7:0] f, input logic [7:0] res,
                                                  input logic c);
    logic [7:0] r;
    r = f;
    r[bbme_pkg::FLAG_C] = c;
    r[bbme_pkg::FLAG_Z] = (res == 8'h00);
    r[bbme_pkg::FLAG_N] = res[7];
    r[bbme_pkg::FLAG_V] = res[7] ^ c;
    bbme_shift_flags = r;
  endfunction

  function automatic logic [4:0] bbme_pair(input logic [4:0] idx);
    bbme_pair = {idx[4:1], 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic accept;
  logic br_op;
  logic br_taken;
  logic [7:0] dst_val;
  logic sel_bit;
  logic [7:0] bit_mask;
  logic sw_flag_wr;
  logic [bbme_pkg::PC_W-1:0] off_ext;
  logic [bbme_pkg::PC_W-1:0] br_target;
  logic [bbme_pkg::PC_W-1:0] pc_next_seq;

  assign accept = instr_valid && (s.state == bbme_pkg::st_idle);
  assign br_op = bbme_is_branch(instr_op);
  assign br_taken = bbme_cond(instr_op, s.flags);
  assign dst_val = s.gpr[instr_dst];
  assign sel_bit = dst_val[instr_bit];
  assign bit_mask = 8'h01 << instr_bit;
  assign sw_flag_wr = reg_write && (reg_addr == bbme_pkg::ADDR_FLAGS);
  // Signed word displacement
  assign off_ext = {{(bbme_pkg::PC_W-bbme_pkg::OFFSET_W){instr_offset[6]}}, instr_offset}; // [RULE16]
  assign br_target = s.pc + off_ext + bbme_pkg::PC_STEP; // [RULE1] [RULE4]
  assign pc_next_seq = s.pc + bbme_pkg::PC_STEP;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr < bbme_pkg::ADDR_IO_BASE) begin
        next_s.rdata = s.gpr[reg_addr[4:0]];
      end else if (reg_addr < bbme_pkg::ADDR_IO_END) begin
        next_s.rdata = s.io[6'(reg_addr - bbme_pkg::ADDR_IO_BASE)];
      end else if (reg_addr == bbme_pkg::ADDR_FLAGS) begin
        next_s.rdata = s.flags;
      end else if (reg_addr == bbme_pkg::ADDR_PC_LO) begin
        next_s.rdata = s.pc[7:0];
      end else if (reg_addr == bbme_pkg::ADDR_PC_HI) begin
        next_s.rdata = 8'(s.pc >> bbme_pkg::BYTE_W);
      end
    end
    if (reg_write) begin
      if (reg_addr < bbme_pkg::ADDR_IO_BASE) begin
        next_s.gpr[reg_addr[4:0]] = reg_wdata;
      end else if (reg_addr < bbme_pkg::ADDR_IO_END) begin
        next_s.io[6'(reg_addr - bbme_pkg::ADDR_IO_BASE)] = reg_wdata;
      end else if (reg_addr == bbme_pkg::ADDR_FLAGS) begin
        next_s.flags = reg_wdata;
      end
    end
    case (s.state)
      bbme_pkg::st_idle: begin
        if (accept) begin
          next_s.pc = pc_next_seq;
          next_s.done = 1'b1;
          if (br_op) begin
            if (br_taken) begin
              // Second cycle loads the target; flags untouched
              next_s.pend_pc = br_target; // [RULE16]
              next_s.state = bbme_pkg::st_branch;
              next_s.busy = 1'b1;
              next_s.done = 1'b0;
              next_s.pc = s.pc;
            end
          end else begin
            case (instr_op)
              bbme_pkg::op_io_bit_set, bbme_pkg::op_io_bit_clear: begin
                // Read-modify-write spread over two cycles
                next_s.pend_addr = instr_io; // [RULE7]
                next_s.pend_bit = instr_bit;
                next_s.pend_val = (instr_op == bbme_pkg::op_io_bit_set);
                next_s.state = bbme_pkg::st_io_write;
                next_s.busy = 1'b1;
                next_s.done = 1'b0;
                next_s.pc = s.pc;
              end
              bbme_pkg::op_shift_left_logical: begin
                next_s.gpr[instr_dst] = {dst_val[6:0], 1'b0}; // [RULE8]
                next_s.flags = bbme_shift_flags(s.flags, {dst_val[6:0], 1'b0}, dst_val[7]);
              end
              bbme_pkg::op_shift_right_logical: begin
                next_s.gpr[instr_dst] = {1'b0, dst_val[7:1]}; // [RULE9]
                next_s.flags = bbme_shift_flags(s.flags, {1'b0, dst_val[7:1]}, dst_val[0]);
              end
              bbme_pkg::op_rotate_left_carry: begin
                next_s.gpr[instr_dst] = {dst_val[6:0], s.flags[bbme_pkg::FLAG_C]}; // [RULE10]
                next_s.flags = bbme_shift_flags(s.flags,
                                                {dst_val[6:0], s.flags[bbme_pkg::FLAG_C]},
                                                dst_val[7]);
              end
              bbme_pkg::op_rotate_right_carry: begin
                next_s.gpr[instr_dst] = {s.flags[bbme_pkg::FLAG_C], dst_val[7:1]}; // [RULE11]
                next_s.flags = bbme_shift_flags(s.flags,
                                                {s.flags[bbme_pkg::FLAG_C], dst_val[7:1]},
                                                dst_val[0]);
              end
              bbme_pkg::op_shift_right_arithmetic: begin
                next_s.gpr[instr_dst] = {dst_val[7], dst_val[7:1]}; // [RULE12]
                next_s.flags = bbme_shift_flags(s.flags, {dst_val[7], dst_val[7:1]}, dst_val[0]);
              end
              bbme_pkg::op_store_bit_to_transfer_flag: begin
                next_s.flags[bbme_pkg::FLAG_T] = sel_bit; // [RULE13]
              end
              bbme_pkg::op_load_bit_from_transfer_flag: begin
                next_s.gpr[instr_dst][instr_bit] = s.flags[bbme_pkg::FLAG_T]; // [RULE13]
              end
              bbme_pkg::op_flag_set: begin
                next_s.flags = s.flags | bit_mask; // [RULE14]
              end
              bbme_pkg::op_flag_clear: begin
                next_s.flags = s.flags & ~bit_mask; // [RULE14]
              end
              bbme_pkg::op_copy_register: begin
                next_s.gpr[instr_dst] = s.gpr[instr_src]; // [RULE15]
              end
              bbme_pkg::op_copy_register_pair: begin
                next_s.gpr[bbme_pair(instr_dst)] = s.gpr[bbme_pair(instr_src)]; // [RULE15]
                next_s.gpr[bbme_pair(instr_dst) | 5'h01] = s.gpr[bbme_pair(instr_src) | 5'h01];
              end
              default: begin
                next_s.pc = pc_next_seq;
              end
            endcase
          end
        end
      end
      bbme_pkg::st_io_write: begin
        next_s.io[s.pend_addr][s.pend_bit] = s.pend_val; // [RULE7]
        next_s.pc = pc_next_seq;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.state = bbme_pkg::st_idle;
      end
      bbme_pkg::st_branch: begin
        next_s.pc = s.pend_pc; // [RULE16]
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.state = bbme_pkg::st_idle;
      end
      default: begin
        next_s.busy = 1'b0;
        next_s.state = bbme_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.flags <= bbme_pkg::FLAGS_RESET;
      s.pc <= bbme_pkg::PC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign busy = s.busy;
  assign done = s.done;
  assign pc = s.pc;
  assign flags = s.flags;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_branch_taken_time: assert property (@(posedge clock) disable iff (!resetn) // [RULE16]
    accept && br_op && br_taken |=> busy && !done ##1 done && !busy)
    else $error("taken branch did not finish in two cycles");

  a_branch_skip_time: assert property (@(posedge clock) disable iff (!resetn) // [RULE16]
    accept && br_op && !br_taken |=> done && !busy && pc == 10'($past(pc) + 10'h001))
    else $error("skipped branch did not finish in one cycle");

  a_branch_target_pc: assert property (@(posedge clock) disable iff (!resetn) // [RULE1]
    accept && br_op && br_taken |-> ##2 pc == $past(br_target, 2))
    else $error("taken branch went to the wrong address");

  a_signed_less_cond: assert property (@(posedge clock) disable iff (!resetn) // [RULE2]
    accept && instr_op == bbme_pkg::op_branch_signed_less |->
      br_taken == (flags[bbme_pkg::FLAG_N] ^ flags[bbme_pkg::FLAG_V]))
    else $error("signed less condition wrong");

  a_branch_keeps_flags: assert property (@(posedge clock) disable iff (!resetn) // [RULE3]
    accept && br_op && !sw_flag_wr |=> flags == $past(flags))
    else $error("branch changed a status flag");

  a_io_two_cycles: assert property (@(posedge clock) disable iff (!resetn) // [RULE7]
    accept && (instr_op == bbme_pkg::op_io_bit_set || instr_op == bbme_pkg::op_io_bit_clear)
      |=> busy && !done ##1 done && !busy)
    else $error("io bit operation not two cycles");

  a_shift_left_flags: assert property (@(posedge clock) disable iff (!resetn) // [RULE8]
    accept && instr_op == bbme_pkg::op_shift_left_logical |=>
      flags[bbme_pkg::FLAG_C] == $past(dst_val[7]) &&
      flags[bbme_pkg::FLAG_V] == (flags[bbme_pkg::FLAG_N] ^ flags[bbme_pkg::FLAG_C]))
    else $error("left shift flags wrong");

  a_rotate_right_carry: assert property (@(posedge clock) disable iff (!resetn) // [RULE11]
    accept && instr_op == bbme_pkg::op_rotate_right_carry |=>
      flags[bbme_pkg::FLAG_C] == $past(dst_val[0]) &&
      flags[bbme_pkg::FLAG_N] == $past(flags[bbme_pkg::FLAG_C]))
    else $error("rotate right carry wrong");

  a_bit_store_flag: assert property (@(posedge clock) disable iff (!resetn) // [RULE13]
    accept && instr_op == bbme_pkg::op_store_bit_to_transfer_flag |=>
      flags[bbme_pkg::FLAG_T] == $past(sel_bit) && done)
    else $error("bit store to transfer flag wrong");

  a_flag_set_only: assert property (@(posedge clock) disable iff (!resetn) // [RULE14]
    accept && instr_op == bbme_pkg::op_flag_set && !sw_flag_wr |=>
      flags == ($past(flags) | $past(bit_mask)))
    else $error("flag set touched other flags");

endmodule // bbme_core

// ### test/branch_bit_move_execution_tb.sv
// Self-checking bench for the branch, bit and move execution core.
`timescale 1ns/10ps
module branch_bit_move_execution_tb;
  logic clock, resetn, instr_valid, reg_write, reg_read, busy, done;
  bbme_pkg::bbme_op_e instr_op;
  logic [4:0] instr_dst, instr_src;
  logic [2:0] instr_bit;
  logic [5:0] instr_io;
  logic [6:0] instr_offset;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, flags, flg;
  logic [9:0] pc, pcm;
  logic [31:0] seed, r;
  logic [7:0] gpr [32];
  logic [7:0] io [64];
  int err_count, n_checks, cyc;

  bbme_core uut (.clock(clock), .resetn(resetn), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_dst(instr_dst), .instr_src(instr_src),
    .instr_bit(instr_bit), .instr_io(instr_io), .instr_offset(instr_offset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy), .done(done),
    .pc(pc), .flags(flags));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, e, what);
  endtask

  // Reference model: updates state, returns expected cycle count
  function automatic int expect_op(input logic [4:0] op, input logic [4:0] d,
      input logic [4:0] s, input logic [2:0] b, input logic [5:0] p, input logic [6:0] k);
    logic [7:0] v;
    logic t;
    v = gpr[d];
    t = 1'b0;
    pcm = pcm + 10'h001;
    case (op)
      5'h00, 5'h01: t = flg[2] ^ op[0];
      5'h02, 5'h03: t = flg[2] ^ flg[3] ^ ~op[0];
      5'h04, 5'h05: t = flg[5] ^ op[0];
      5'h06, 5'h07: t = flg[6] ^ op[0];
      5'h08, 5'h09: t = flg[3] ^ op[0];
      5'h0a, 5'h0b: t = flg[7] ^ op[0];
      5'h0c, 5'h0d: io[p][b] = ~op[0];
      5'h0e: {flg[0], v} = {v, 1'b0};
      5'h0f: {v, flg[0]} = {1'b0, v};
      5'h10: {flg[0], v} = {v, flg[0]};
      5'h11: {v, flg[0]} = {flg[0], v};
      5'h12: {v, flg[0]} = {v[7], v};
      5'h13: flg[6] = v[b];
      5'h14: v[b] = flg[6];
      5'h15, 5'h16: flg[b] = op[0];
      5'h17: v = gpr[s];
      5'h18: begin
        gpr[d | 5'h01] = gpr[s | 5'h01];
        v = gpr[s & 5'h1e];
      end
      default: v = gpr[d];
    endcase
    if (op >= 5'h0e && op <= 5'h12) begin
      flg[1] = (v == 8'h00);
      flg[2] = v[7];
      flg[3] = v[7] ^ flg[0];
    end
    gpr[(op == 5'h18) ? (d & 5'h1e) : d] = v;
    if (t) begin
      pcm = pcm + {{3{k[6]}}, k};
      return 2;
    end
    return (op == 5'h0c || op == 5'h0d) ? 2 : 1;
  endfunction

  task automatic run_op(input logic [4:0] op);
    int ncyc, n;
    logic [31:0] q;
    logic [6:0] k;
    seed = lfsr(seed);
    q = seed;
    k = (q[31:30] == 2'b00) ? 7'h40 : (q[31:30] == 2'b01) ? 7'h3f : q[25:19];
    reg_wr(8'h60, q[7:0]);
    flg = q[7:0];
    reg_wr({3'b000, q[4:0]}, q[15:8]);
    gpr[q[4:0]] = q[15:8];
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_op <= bbme_pkg::bbme_op_e'(op);
    instr_dst <= q[4:0];
    instr_src <= q[9:5];
    instr_bit <= q[12:10];
    instr_io <= q[18:13];
    instr_offset <= k;
    ncyc = expect_op(op, q[4:0], q[9:5], q[12:10], q[18:13], k);
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    check({9'h000, busy}, {9'h000, ncyc == 2}, "busy");
    n = 1;
    while (done !== 1'b1 && n < 6) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(10'(n), 10'(ncyc), "cycles");
    check(pc, pcm, "pc");
    check({2'b00, flags}, {2'b00, flg}, "flags");
    if (op == 5'h0c || op == 5'h0d)
      reg_chk(8'h20 + {2'b00, q[18:13]}, io[q[18:13]], "io");
    else
      reg_chk({3'b000, q[4:0]}, gpr[q[4:0]], "gpr");
    if (op == 5'h18)
      reg_chk({3'b000, q[4:0] ^ 5'h01}, gpr[q[4:0] ^ 5'h01], "pair");
  endtask

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_op = bbme_pkg::op_none;
    instr_dst = 5'h00;
    instr_src = 5'h00;
    instr_bit = 3'h0;
    instr_io = 6'h00;
    instr_offset = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    seed = 32'd87777;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    flg = 8'h00;
    pcm = 10'h000;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    #1;
    check(pc, 10'h000, "pc reset");
    check({2'b00, flags}, 10'h000, "flags reset");
    check({8'h00, busy, done}, 10'h000, "busy done reset");
    reg_chk(8'h80, 8'h00, "unmapped read");
    reg_wr(8'h61, 8'hff);
    #1;
    check(pc, 10'h000, "pc write ignored");
    $display("test reset and port done");
    for (int i = 0; i < 96; i++) begin
      seed = lfsr(seed);
      r = seed;
      reg_wr(8'(i), r[7:0]);
      if (i < 32)
        gpr[i] = r[7:0];
      else
        io[i - 32] = r[7:0];
    end
    $display("test preload done");
    for (int i = 0; i < 96; i++)
      run_op(5'(i));
    $display("test every code done");
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      r = seed;
      run_op(r[20:16]);
    end
    reg_chk(8'h61, pc[7:0], "pc low");
    reg_chk(8'h62, {6'h00, pc[9:8]}, "pc high");
    $display("test random ops done");
    end_sim();
  end
endmodule // branch_bit_move_execution_tb
